// *** rtl/rsch_top.sv ***
// Command handshake of a fieldbus remote device station inside a motor drive.
// Assumes the link flags/words are synchronous to clock and refreshed by the master.
// Function
// - Frequency word applied on RAM-write command, set-done raised in the same cycle.
// - Reply code presented in read word 2 with set-done.
// - Nonvolatile frequency write happens once, when EEPROM command turns on.
// - Set-frequency changes ignored while EEPROM command stays on.
// - Instruction code executed on request; done raised with reply and result.
// - Code H74 returns fault history entries one and two.
// - Code H87 writes acceleration time in 0.1 s units.
// - Error reset honoured only while an error is present.
// - Reset select zero allows communication reset in any mode.
// - HFD with H9696 resets, only if startup nonzero or network mode.
// - In network operation only link run commands are accepted.
// - Communication loss fault in network mode after silence longer than wait time.
// - Startup select zero returns to external mode after power restore.
// - Startup select nonzero enters network mode after inverter reset.
`timescale 1ns/100ps
module rsch_top
  import rsch_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)(
  input  wire logic           clock,
  input  wire logic           nrst,
  input  wire logic [7:0]     addr,
  input  wire logic [31:0]    wdata,
  input  wire logic           wr_en,
  input  wire logic           rd_en,
  output logic [31:0]         rdata,
  input  wire rsch_link_in_s  link_in,
  output rsch_link_out_s      link_out,
  input  wire logic           fault_in,
  input  wire logic [7:0]     fault_code,
  input  wire logic           power_restored,
  input  wire logic [1:0]     ext_run_cmd,
  input  wire logic [1:0]     pu_run_cmd,
  output logic [1:0]          run_cmd,
  output logic [15:0]         running_freq,
  output logic                eeprom_wr_en,
  output logic [15:0]         eeprom_wr_data,
  output logic                inverter_reset,
  output logic                comm_loss_fault,
  output logic                irq
);
  // ==========================================================================
  // Reset release
  logic rst_meta_reg;
  logic rst_n;
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // ==========================================================================
  // State
  logic [7:0]     startup_reg;
  logic           rst_sel_reg;
  logic [15:0]    wait_reg;
  logic [IRQ_W-1:0] istat_reg;
  logic [IRQ_W-1:0] imask_reg;
  logic [15:0]    accel_reg;
  logic [7:0]     hist1_reg;
  logic [7:0]     hist2_reg;
  logic           err_reg;
  logic           err_d_reg;
  rsch_mode_e     mode_reg;
  logic [IRQ_W-1:0] ev;
  logic           do_reset;
  logic           instr_go;
  logic           instr_reset;
  logic           freq_go;
  logic           eep_go;
  logic           comm_loss_set;
  logic           new_fault;
  logic           net;
  logic           set_done_reg;
  logic           eep_done_reg;
  logic           instr_done_reg;
  logic [15:0]    reply_reg;
  logic [15:0]    result_reg;

  assign net       = (mode_reg == MODE_NET);
  // One driver for the whole link output word
  assign link_out  = '{set_done_reg, eep_done_reg, instr_done_reg, err_reg, net,
                       reply_reg, result_reg};
  assign freq_go   = link_in.freq_ram_write_cmd && !link_out.freq_set_done;
  assign eep_go    = link_in.freq_eeprom_write_cmd && !link_out.freq_eeprom_done;
  assign instr_go  = link_in.instr_exec_req && !link_out.instr_exec_done;
  assign instr_reset = instr_go && link_in.write_word_instr_code == INSTR_RESET
                     && link_in.write_word_instr_data == DATA_RESET
                     && (startup_reg != STARTUP_RST || net);
  // Error reset refused outside network mode unless select is zero
  assign do_reset  = (link_in.error_reset_req && err_reg
                     && (!rst_sel_reg || net))
                   || instr_reset || power_restored;
  assign new_fault = err_reg && !err_d_reg;

  // ==========================================================================
  // Register bus
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      startup_reg <= STARTUP_RST;
      rst_sel_reg <= 1'b0;
      wait_reg    <= WAIT_RST;
      imask_reg   <= '0;
    end
    else if (wr_en)
    begin
      case (addr)
        ADDR_CTRL:
        begin
          startup_reg <= wdata[7:0];
          rst_sel_reg <= wdata[CTRL_RST_SEL_BIT];
        end
        ADDR_WAIT:  wait_reg  <= wdata[15:0];
        ADDR_IMASK: imask_reg <= wdata[IRQ_W-1:0];
        default:    ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= '0;
    else if (rd_en)
    begin
      case (addr)
        ADDR_CTRL:  rdata <= {23'h0, rst_sel_reg, startup_reg};
        ADDR_WAIT:  rdata <= {16'h0, wait_reg};
        ADDR_ISTAT: rdata <= {27'h0, istat_reg};
        ADDR_IMASK: rdata <= {27'h0, imask_reg};
        ADDR_STATE: rdata <= {29'h0, comm_loss_fault, err_reg, net};
        ADDR_FREQ:  rdata <= {16'h0, running_freq};
        ADDR_ACCEL: rdata <= {16'h0, accel_reg};
        ADDR_FHIST: rdata <= {16'h0, hist2_reg, hist1_reg};
        default:    rdata <= '0;
      endcase
    end
    else
      rdata <= '0;
  end

  // ==========================================================================
  // Interrupts: new events win over a clearing read
  assign ev[IRQ_FREQ]      = freq_go;
  assign ev[IRQ_EEPROM]    = eep_go;
  assign ev[IRQ_INSTR]     = instr_go;
  assign ev[IRQ_FAULT]     = new_fault;
  assign ev[IRQ_COMM_LOSS] = comm_loss_set;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      istat_reg <= '0;
    else if (rd_en && addr == ADDR_ISTAT)
      istat_reg <= ev;
    else
      istat_reg <= istat_reg | ev;
  end
  assign irq = |(istat_reg & imask_reg);

  // ==========================================================================
  // Frequency handshakes
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      running_freq              <= '0;
      set_done_reg              <= 1'b0;
      eep_done_reg              <= 1'b0;
      eeprom_wr_en              <= 1'b0;
      eeprom_wr_data            <= '0;
    end
    else
    begin
      eeprom_wr_en <= eep_go;
      if (eep_go)
      begin
        running_freq   <= link_in.write_word_set_freq;
        eeprom_wr_data <= link_in.write_word_set_freq;
      end
      else if (freq_go && !link_in.freq_eeprom_write_cmd)
        running_freq <= link_in.write_word_set_freq;
      if (freq_go)
        set_done_reg <= 1'b1;
      else if (!link_in.freq_ram_write_cmd)
        set_done_reg <= 1'b0;
      if (eep_go)
        eep_done_reg <= 1'b1;
      else if (!link_in.freq_eeprom_write_cmd)
        eep_done_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Instruction execution
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      instr_done_reg            <= 1'b0;
      reply_reg                 <= REPLY_OK;
      result_reg                <= '0;
      accel_reg                 <= ACCEL_RST;
    end
    else if (freq_go || eep_go)
    begin
      reply_reg <= REPLY_OK;
      if (!link_in.instr_exec_req)
        instr_done_reg <= 1'b0;
    end
    else if (instr_go)
    begin
      instr_done_reg <= 1'b1;
      reply_reg      <= REPLY_OK;
      case (link_in.write_word_instr_code)
        INSTR_FHIST:
          result_reg <= {hist2_reg, hist1_reg};
        INSTR_ACCEL_RD:
          result_reg <= accel_reg;
        INSTR_ACCEL_WR:
          accel_reg <= link_in.write_word_instr_data;
        INSTR_MODE_WR:
          if (link_in.write_word_instr_data != DATA_MODE_NET
              && link_in.write_word_instr_data != DATA_MODE_EXT)
            reply_reg <= REPLY_REFUSED;
        INSTR_RESET:
          if (!instr_reset)
            reply_reg <= REPLY_REFUSED;
        default:
          reply_reg <= REPLY_BAD_CODE;
      endcase
    end
    else if (!link_in.instr_exec_req)
      instr_done_reg <= 1'b0;
  end

  // ==========================================================================
  // Operation mode
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      mode_reg <= MODE_EXT;
    else if (do_reset)
      mode_reg <= (startup_reg != STARTUP_RST) ? MODE_NET : MODE_EXT;
    else if (instr_go && link_in.write_word_instr_code == INSTR_MODE_WR)
    begin
      if (link_in.write_word_instr_data == DATA_MODE_NET)
        mode_reg <= MODE_NET;
      else if (link_in.write_word_instr_data == DATA_MODE_EXT)
        mode_reg <= MODE_EXT;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_cmd        <= '0;
      inverter_reset <= 1'b0;
    end
    else
    begin
      case (mode_reg)
        MODE_NET: run_cmd <= link_in.run_cmd;
        MODE_EXT: run_cmd <= ext_run_cmd | pu_run_cmd;
        default:  run_cmd <= '0;
      endcase
      inverter_reset <= do_reset;
    end
  end

  // ==========================================================================
  // Faults and communication watchdog
  // Tick prescaler keeps the wait counter narrow; wait is in 0.1 s units.
  logic [$clog2(TICK_CYCLES+1)-1:0] pre_reg;
  logic [16:0]                      ticks_reg;
  logic                             tick;
  assign tick = (pre_reg == ($clog2(TICK_CYCLES+1))'(TICK_CYCLES - 1));
  assign comm_loss_set = net && !comm_loss_fault && !do_reset
                       && (ticks_reg > {1'b0, wait_reg});

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_reg   <= '0;
      ticks_reg <= '0;
    end
    else if (!net || link_in.refresh || comm_loss_fault)
    begin
      pre_reg   <= '0;
      ticks_reg <= '0;
    end
    else
    begin
      pre_reg <= tick ? '0 : pre_reg + 1'b1;
      if (tick && ticks_reg != '1)
        ticks_reg <= ticks_reg + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      comm_loss_fault <= 1'b0;
      err_reg         <= 1'b0;
      err_d_reg       <= 1'b0;
      hist1_reg       <= '0;
      hist2_reg       <= '0;
    end
    else
    begin
      err_d_reg <= err_reg;
      // A fault in the reset cycle survives the reset
      if (comm_loss_set)
        comm_loss_fault <= 1'b1;
      else if (do_reset)
        comm_loss_fault <= 1'b0;
      if (comm_loss_set || fault_in)
        err_reg <= 1'b1;
      else if (do_reset)
        err_reg <= 1'b0;
      // A fault raised while no error is present shifts the older one down the history
      if (!err_reg && (comm_loss_set || fault_in))
      begin
        hist2_reg <= hist1_reg;
        hist1_reg <= comm_loss_set ? FAULT_COMM_LOSS : fault_code;
      end
    end
  end
  // ==========================================================================
  // Checks
  property p_freq_apply;
    @(posedge clock) disable iff (!rst_n)
    freq_go && !link_in.freq_eeprom_write_cmd |=>
      link_out.freq_set_done && running_freq == $past(link_in.write_word_set_freq);
  endproperty
  a_freq_apply: assert property (p_freq_apply) else $error("freq not applied");

  property p_freq_reply;
    @(posedge clock) disable iff (!rst_n)
    freq_go |=> link_out.read_word_reply == REPLY_OK;
  endproperty
  a_freq_reply: assert property (p_freq_reply) else $error("bad freq reply");

  property p_eep_once;
    @(posedge clock) disable iff (!rst_n)
    eeprom_wr_en |=> !eeprom_wr_en;
  endproperty
  a_eep_once: assert property (p_eep_once) else $error("eeprom written twice");

  property p_eep_hold;
    @(posedge clock) disable iff (!rst_n)
    link_in.freq_eeprom_write_cmd && link_out.freq_eeprom_done ##1
      link_in.freq_eeprom_write_cmd |-> $stable(running_freq);
  endproperty
  a_eep_hold: assert property (p_eep_hold) else $error("freq changed under eeprom");

  property p_instr_done;
    @(posedge clock) disable iff (!rst_n)
    $rose(link_in.instr_exec_req) && !link_out.instr_exec_done && !freq_go && !eep_go
      |=> link_out.instr_exec_done;
  endproperty
  a_instr_done: assert property (p_instr_done) else $error("instr not done");

  property p_fhist;
    @(posedge clock) disable iff (!rst_n)
    instr_go && !freq_go && !eep_go && link_in.write_word_instr_code == INSTR_FHIST
      |=> link_out.read_word_result == {$past(hist2_reg), $past(hist1_reg)};
  endproperty
  a_fhist: assert property (p_fhist) else $error("bad fault history");

  property p_err_reset;
    @(posedge clock) disable iff (!rst_n)
    inverter_reset |-> $past(link_in.error_reset_req && err_reg) || $past(instr_reset)
      || $past(power_restored);
  endproperty
  a_err_reset: assert property (p_err_reset) else $error("reset without cause");

  property p_net_run;
    @(posedge clock) disable iff (!rst_n)
    net && $past(net) |-> run_cmd == $past(link_in.run_cmd);
  endproperty
  a_net_run: assert property (p_net_run) else $error("foreign run command");

  property p_done_clear;
    @(posedge clock) disable iff (!rst_n)
    !link_in.freq_ram_write_cmd |=> !link_out.freq_set_done;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done stuck");

  c_freq:  cover property (@(posedge clock) disable iff (!rst_n) freq_go ##[2:40] freq_go);
  c_eep:   cover property (@(posedge clock) disable iff (!rst_n) eep_go);
  c_instr: cover property (@(posedge clock) disable iff (!rst_n) instr_reset);
  c_loss:  cover property (@(posedge clock) disable iff (!rst_n) comm_loss_set);
endmodule : rsch_top

// *** rtl/rsch_pkg.sv ***
// Constants, types and register map of the remote station command handshake.
// Assumes one 20 MHz clock; the link words arrive already refreshed and synchronous.
package rsch_pkg;
  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int WAIT_UNIT_MS  = 100;
  localparam int TICK_CYC      = (WAIT_UNIT_MS * 1_000_000) / CLK_PERIOD_NS;

  // ==========================================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_WAIT   = 8'h04;
  localparam logic [7:0] ADDR_ISTAT  = 8'h08;
  localparam logic [7:0] ADDR_IMASK  = 8'h0c;
  localparam logic [7:0] ADDR_STATE  = 8'h10;
  localparam logic [7:0] ADDR_FREQ   = 8'h14;
  localparam logic [7:0] ADDR_ACCEL  = 8'h18;
  localparam logic [7:0] ADDR_FHIST  = 8'h1c;

  // CTRL fields and reset values
  localparam int         CTRL_RST_SEL_BIT = 8;
  localparam logic [7:0] STARTUP_RST      = 8'h00;
  localparam logic [15:0] WAIT_RST        = 16'h0000;
  localparam logic [15:0] ACCEL_RST       = 16'h0032;

  // Interrupt bits
  localparam int IRQ_W         = 5;
  localparam int IRQ_FREQ      = 0;
  localparam int IRQ_EEPROM    = 1;
  localparam int IRQ_INSTR     = 2;
  localparam int IRQ_FAULT     = 3;
  localparam int IRQ_COMM_LOSS = 4;

  // ==========================================================================
  // Instruction codes, data and reply codes
  localparam logic [15:0] INSTR_FHIST     = 16'h0074;
  localparam logic [15:0] INSTR_ACCEL_RD  = 16'h0007;
  localparam logic [15:0] INSTR_ACCEL_WR  = 16'h0087;
  localparam logic [15:0] INSTR_MODE_WR   = 16'h00fb;
  localparam logic [15:0] INSTR_RESET     = 16'h00fd;
  localparam logic [15:0] DATA_RESET      = 16'h9696;
  localparam logic [15:0] DATA_MODE_NET   = 16'h0000;
  localparam logic [15:0] DATA_MODE_EXT   = 16'h0010;
  localparam logic [15:0] REPLY_OK        = 16'h0000;
  localparam logic [15:0] REPLY_BAD_CODE  = 16'h0001;
  localparam logic [15:0] REPLY_REFUSED   = 16'h0002;
  localparam logic [7:0]  FAULT_COMM_LOSS = 8'ha1;

  typedef enum logic [1:0] {
    MODE_EXT = 2'b01,
    MODE_NET = 2'b10
  } rsch_mode_e;

  typedef struct packed {
    logic        freq_ram_write_cmd;
    logic        freq_eeprom_write_cmd;
    logic        instr_exec_req;
    logic        error_reset_req;
    logic        refresh;
    logic [1:0]  run_cmd;
    logic [15:0] write_word_set_freq;
    logic [15:0] write_word_instr_code;
    logic [15:0] write_word_instr_data;
  } rsch_link_in_s;

  typedef struct packed {
    logic        freq_set_done;
    logic        freq_eeprom_done;
    logic        instr_exec_done;
    logic        error_status_flag;
    logic        net_mode;
    logic [15:0] read_word_reply;
    logic [15:0] read_word_result;
  } rsch_link_out_s;
endpackage : rsch_pkg

// *** verification/rsch_master_model.sv ***
// Fieldbus master model driving the link flags and words of the station.
// Assumes link_out is registered on clock; tasks are called after reset release.
`timescale 1ns/100ps
module rsch_master_model
  import rsch_pkg::*;
(
  input  wire logic           clock,
  output rsch_link_in_s       link_in,
  input  wire rsch_link_out_s link_out
);
  logic refresh_on;

  initial
  begin
    link_in    = '0;
    refresh_on = 1'b1;
  end

  // ==========================================================================
  // Cyclic exchange, one pulse every other cycle while the link is alive
  // Single station on this link, so its number cannot clash
  always @(posedge clock)
    link_in.refresh <= refresh_on & ~link_in.refresh;

  // ==========================================================================
  // Handshakes
  task automatic freq_start(input logic ee, input logic [15:0] word, output logic [15:0] reply);
    reply = 'x;
    @(posedge clock);
    link_in.write_word_set_freq <= word;
    @(posedge clock);
    link_in.freq_ram_write_cmd    <= ~ee;
    link_in.freq_eeprom_write_cmd <= ee;
    @(posedge clock);
    for (int i = 0; i < 20 && (ee ? link_out.freq_eeprom_done : link_out.freq_set_done) !== 1'b1; i++)
      @(posedge clock);
    if ((ee ? link_out.freq_eeprom_done : link_out.freq_set_done) === 1'b1)
      reply = link_out.read_word_reply;
  endtask : freq_start

  task automatic freq_stop(input logic ee);
    @(posedge clock);
    link_in.freq_ram_write_cmd    <= 1'b0;
    link_in.freq_eeprom_write_cmd <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 20 && (ee ? link_out.freq_eeprom_done : link_out.freq_set_done) !== 1'b0; i++)
      @(posedge clock);
  endtask : freq_stop

  task automatic set_word(input logic [15:0] word);
    @(posedge clock);
    link_in.write_word_set_freq <= word;
  endtask : set_word

  task automatic set_run(input logic [1:0] run);
    @(posedge clock);
    link_in.run_cmd <= run;
  endtask : set_run

  task automatic instr(input logic [15:0] code, data, output logic [15:0] reply, result);
    reply  = 'x;
    result = 'x;
    @(posedge clock);
    // Only parameter codes below 100 are used: extended setting stays zero
    link_in.write_word_instr_code <= code;
    link_in.write_word_instr_data <= data;
    link_in.instr_exec_req        <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 20 && link_out.instr_exec_done !== 1'b1; i++)
      @(posedge clock);
    if (link_out.instr_exec_done === 1'b1)
    begin
      reply  = link_out.read_word_reply;
      result = link_out.read_word_result;
    end
    link_in.instr_exec_req <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 20 && link_out.instr_exec_done !== 1'b0; i++)
      @(posedge clock);
  endtask : instr

  task automatic err_reset;
    @(posedge clock);
    link_in.error_reset_req <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 20 && link_out.error_status_flag !== 1'b0; i++)
      @(posedge clock);
    link_in.error_reset_req <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : err_reset
endmodule : rsch_master_model

// *** verification/remote_station_command_handshake_tb_top.sv ***
// Self-checking bench of the station command handshake.
// Assumes rsch_top with a short tick; the master model sits on the link side.
`timescale 1ns/100ps
module remote_station_command_handshake_tb_top
  import rsch_pkg::*;
;
  typedef struct packed {
    logic [15:0] code;
    logic [15:0] data;
    logic [15:0] reply;
    logic [15:0] result;
    logic        use_res;
  } rsch_row_s;

  logic           clock, nrst, wr_en, rd_en, fault_in, power_restored;
  logic [7:0]     addr, fault_code;
  logic [31:0]    wdata, rdata;
  logic [1:0]     ext_run_cmd, pu_run_cmd, run_cmd;
  logic [15:0]    running_freq, eeprom_wr_data, rep, res;
  logic           eeprom_wr_en, inverter_reset, comm_loss_fault, irq;
  rsch_link_in_s  link_in;
  rsch_link_out_s link_out;
  int             failures, tests_run, inv_cnt, ee_cnt;
  rsch_row_s      rows [8];

  rsch_top #(.TICK_CYCLES(4)) u_rsch_top (
    .clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .link_in(link_in), .link_out(link_out), .fault_in(fault_in),
    .fault_code(fault_code), .power_restored(power_restored), .ext_run_cmd(ext_run_cmd),
    .pu_run_cmd(pu_run_cmd), .run_cmd(run_cmd), .running_freq(running_freq),
    .eeprom_wr_en(eeprom_wr_en), .eeprom_wr_data(eeprom_wr_data),
    .inverter_reset(inverter_reset), .comm_loss_fault(comm_loss_fault), .irq(irq));

  rsch_master_model u_rsch_master_model (
    .clock(clock), .link_in(link_in), .link_out(link_out));

  // ==========================================================================
  // Clock, pulse counters, watchdog
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  always @(posedge clock)
  begin
    if (inverter_reset === 1'b1)
      inv_cnt++;
    if (eeprom_wr_en === 1'b1)
      ee_cnt++;
  end

  initial
  begin
    #(50 * 20000);
    failures++;
    end_of_test();
  end

  // ==========================================================================
  // Helpers
  task automatic chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test;
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, msk);
    @(posedge clock);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    @(posedge clock);
    chk(rdata & msk, exp);
  endtask : reg_rd

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc

  // ==========================================================================
  // Main sequence
  initial
  begin
    nrst = 1'b0; wr_en = 1'b0; rd_en = 1'b0; addr = 8'h00; wdata = 32'h0;
    fault_in = 1'b0; fault_code = 8'h00; power_restored = 1'b0;
    ext_run_cmd = 2'b00; pu_run_cmd = 2'b00;
    rows[0] = '{INSTR_ACCEL_WR, 16'h001e, REPLY_OK, 16'h0000, 1'b0};
    rows[1] = '{INSTR_ACCEL_RD, 16'h0000, REPLY_OK, 16'h001e, 1'b1};
    rows[2] = '{INSTR_FHIST, 16'h0000, REPLY_OK, 16'h0000, 1'b1};
    rows[3] = '{16'h0055, 16'h0000, REPLY_BAD_CODE, 16'h0000, 1'b0};
    rows[4] = '{INSTR_MODE_WR, 16'h0005, REPLY_REFUSED, 16'h0000, 1'b0};
    rows[5] = '{INSTR_RESET, DATA_RESET, REPLY_REFUSED, 16'h0000, 1'b0};
    rows[6] = '{INSTR_MODE_WR, DATA_MODE_NET, REPLY_OK, 16'h0000, 1'b0};
    rows[7] = '{INSTR_RESET, DATA_RESET, REPLY_OK, 16'h0000, 1'b0};
    cyc(10);
    nrst <= 1'b1;
    cyc(3);
    reg_rd(ADDR_CTRL, 32'h0, '1);
    reg_rd(ADDR_ACCEL, {16'h0, ACCEL_RST}, '1);
    reg_wr(ADDR_ACCEL, 32'h5);
    reg_rd(ADDR_ACCEL, {16'h0, ACCEL_RST}, '1);
    reg_rd(8'h20, 32'h0, '1);
    reg_rd(ADDR_STATE, 32'h0, '1);
    reg_wr(ADDR_WAIT, 32'h2);
    reg_wr(ADDR_IMASK, 32'h1 << IRQ_INSTR);
    foreach (rows[i])
    begin
      u_rsch_master_model.instr(rows[i].code, rows[i].data, rep, res);
      chk(rep, rows[i].reply);
      if (rows[i].use_res)
        chk(res, rows[i].result);
    end
    chk(inv_cnt, 1);
    chk(irq, 1'b1);
    reg_rd(ADDR_ISTAT, 32'h1 << IRQ_INSTR, 32'h1 << IRQ_INSTR);
    cyc(2);
    chk(irq, 1'b0);
    u_rsch_master_model.instr(INSTR_MODE_WR, DATA_MODE_NET, rep, res);
    chk(link_out.net_mode, 1'b1);
    // Two back-to-back volatile updates
    u_rsch_master_model.freq_start(1'b0, 16'h1388, rep);
    chk(rep, REPLY_OK);
    chk(running_freq, 16'h1388);
    u_rsch_master_model.freq_stop(1'b0);
    chk(link_out.freq_set_done, 1'b0);
    u_rsch_master_model.freq_start(1'b0, 16'h0fa0, rep);
    chk(running_freq, 16'h0fa0);
    u_rsch_master_model.freq_stop(1'b0);
    // Nonvolatile write, then a word change that must be ignored
    u_rsch_master_model.freq_start(1'b1, 16'h0bb8, rep);
    cyc(1);
    chk(ee_cnt, 1);
    chk(eeprom_wr_data, 16'h0bb8);
    chk(running_freq, 16'h0bb8);
    u_rsch_master_model.set_word(16'h0123);
    cyc(6);
    chk(running_freq, 16'h0bb8);
    chk(ee_cnt, 1);
    u_rsch_master_model.freq_stop(1'b1);
    chk(link_out.freq_eeprom_done, 1'b0);
    ext_run_cmd <= 2'b01;
    pu_run_cmd  <= 2'b11;
    u_rsch_master_model.set_run(2'b10);
    cyc(3);
    chk(run_cmd, 2'b10);
    // Link silence: three ticks of four cycles must pass first
    reg_rd(ADDR_ISTAT, 32'h7, 32'h1f);
    reg_wr(ADDR_IMASK, 32'h1 << IRQ_COMM_LOSS);
    u_rsch_master_model.refresh_on <= 1'b0;
    cyc(5);
    chk(comm_loss_fault, 1'b0);
    for (int i = 0; i < 40 && comm_loss_fault !== 1'b1; i++)
      @(posedge clock);
    chk(comm_loss_fault, 1'b1);
    chk(link_out.error_status_flag, 1'b1);
    chk(irq, 1'b1);
    reg_rd(ADDR_ISTAT, 32'h1 << IRQ_COMM_LOSS, 32'h1 << IRQ_COMM_LOSS);
    cyc(2);
    chk(irq, 1'b0);
    u_rsch_master_model.refresh_on <= 1'b1;
    u_rsch_master_model.instr(INSTR_FHIST, 16'h0000, rep, res);
    chk(res[7:0], FAULT_COMM_LOSS);
    reg_wr(ADDR_CTRL, 32'h1);
    u_rsch_master_model.err_reset();
    chk(inv_cnt, 2);
    chk(link_out.error_status_flag, 1'b0);
    chk(link_out.net_mode, 1'b1);
    u_rsch_master_model.err_reset();
    chk(inv_cnt, 2);
    // Reset from the link while in external mode, first refused by reset select
    reg_wr(ADDR_CTRL, 32'h100);
    u_rsch_master_model.instr(INSTR_MODE_WR, DATA_MODE_EXT, rep, res);
    chk(link_out.net_mode, 1'b0);
    chk(run_cmd, 2'b11);
    pu_run_cmd <= 2'b00;
    cyc(2);
    chk(run_cmd, 2'b01);
    u_rsch_master_model.refresh_on <= 1'b0;
    cyc(30);
    chk(comm_loss_fault, 1'b0);
    u_rsch_master_model.refresh_on <= 1'b1;
    @(posedge clock);
    fault_in   <= 1'b1;
    fault_code <= 8'h33;
    @(posedge clock);
    fault_in <= 1'b0;
    cyc(2);
    chk(link_out.error_status_flag, 1'b1);
    u_rsch_master_model.instr(INSTR_FHIST, 16'h0000, rep, res);
    chk(res, 16'ha133);
    u_rsch_master_model.err_reset();
    chk(inv_cnt, 2);
    chk(link_out.error_status_flag, 1'b1);
    reg_wr(ADDR_CTRL, 32'h0);
    u_rsch_master_model.err_reset();
    chk(inv_cnt, 3);
    u_rsch_master_model.instr(INSTR_MODE_WR, DATA_MODE_NET, rep, res);
    chk(link_out.net_mode, 1'b1);
    @(posedge clock);
    power_restored <= 1'b1;
    @(posedge clock);
    power_restored <= 1'b0;
    cyc(3);
    chk(link_out.net_mode, 1'b0);
    end_of_test();
  end
endmodule : remote_station_command_handshake_tb_top
